/* File: rtl/eep_regs.vh */
`ifndef EEP_REGS_VH
`define EEP_REGS_VH
// Device-type identifier; value is arbitrary, chosen for this design.
`define EEP_DEV_TYPE      4'h5
`define EEP_RD_BIT        1'b1
`define EEP_PAGE_BYTES    64
`define EEP_PAGE_MASK     15'h003F
`define EEP_HI_MASK       8'h7F
// Write cycle time in microseconds and the clock rate in MHz.
`define EEP_TWR_US        6000
`define EEP_CLK_MHZ       20
`define EEP_TWR_CYCLES    (`EEP_TWR_US * `EEP_CLK_MHZ)
`define EEP_BIT_LAST      3'h7
`define EEP_MEM_WORDS     32768
`endif

/* File: rtl/eep_slave.v */
`timescale 1ns/1ns
// Summary of operation
// RQ1 - Program cycle starts at stop, within 6 ms.
// RQ2 - Address byte: type, block, direction.
// RQ3 - Ignore mismatching device type field.
// RQ4 - Block field must match select pins.
// RQ5 - Direction bit one reads, zero writes.
// RQ6 - Receiver pulls data low on ninth clock.
// RQ7 - Transmitter releases line, samples ninth clock.
// RQ8 - Two array address bytes follow address.
// RQ9 - First byte high, second byte low.
// RQ10 - Write protect blocks programming, reads still work.
// RQ11 - Protected: data bytes not acknowledged.
// RQ12 - Open protect input reads as low.
// RQ13 - Master starts every transaction with start.
// RQ14 - Acknowledge continues; no acknowledge ends.
// RQ15 - Master ends each transaction with stop.
// RQ16 - Page write takes up to 64 bytes.
// RQ17 - Data line driven only low.
// RQ18 - Top bit of high address ignored.
// RQ19 - Page write wraps within same page.
// RQ20 - No address acknowledge while programming.
// RQ21 - Data changes only while clock low.
// RQ22 - Start or stop mid-byte abandons transfer.
`include "eep_regs.vh"
module eep_slave #(
  parameter TWR_CYCLES = `EEP_TWR_CYCLES
) (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire       device_select_pin_0_i,
  input  wire       device_select_pin_1_i,
  input  wire       device_select_pin_2_i,
  input  wire       write_protect_i,
  output reg        busy_o
);

  // ------------------------------------------------------------------
  // Frame states
  // ------------------------------------------------------------------
  // ST_ACK is reserved; the ninth clock is tracked by ack_phase instead.
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_DEV  = 7'h02;
  localparam [6:0] ST_AHI  = 7'h04;
  localparam [6:0] ST_ALO  = 7'h08;
  localparam [6:0] ST_WDAT = 7'h10;
  localparam [6:0] ST_RDAT = 7'h20;
  localparam [6:0] ST_ACK  = 7'h40;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [1:0] wp_sync;
  reg [2:0] sel_s1;
  reg [2:0] sel_s2;
  reg       scl_d;
  reg       sda_d;

  // Two flops on every pin; only the second stage is read by logic.
  // The bus pins reset to idle-high, so no false edge follows reset.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync  <= 2'h0;
      sel_s1   <= 3'h0;
      sel_s2   <= 3'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      wp_sync  <= {wp_sync[0], write_protect_i};
      sel_s1   <= {device_select_pin_2_i, device_select_pin_1_i, device_select_pin_0_i};
      sel_s2   <= sel_s1;
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  wire scl      = scl_sync[1];
  wire sda      = sda_sync[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // Both bus lines pass equal delays, so their order of change is kept.
  // RQ21 start stop detect
  wire start_ev = scl & scl_d & sda_d & ~sda;
  wire stop_ev  = scl & scl_d & ~sda_d & sda;
  // RQ12 protect pull-down
  // Only a clear high level protects; reset leaves the array writable, the
  // same as an open pin that the internal pull-down holds low.
  wire wp       = wp_sync[1];

  // ------------------------------------------------------------------
  // Protocol state
  // ------------------------------------------------------------------
  reg [7:0]  mem [0:`EEP_MEM_WORDS-1];
  reg [7:0]  page [0:`EEP_PAGE_BYTES-1];
  reg [`EEP_PAGE_BYTES-1:0] page_vld;
  reg [6:0]  state;
  reg [6:0]  ret_state;
  reg [7:0]  shreg;
  reg [2:0]  bitcnt;
  reg [14:0] addr;
  reg [14:0] page_base;
  reg        have_data;
  reg        ack_drive;
  reg        ack_phase;
  reg        tx_ack_ok;
  reg [7:0]  addr_hi;
  reg [23:0] twr_cnt;
  reg [6:0]  prog_idx;
  reg        programming;
  // Set by a clock rise inside the frame; a fall only counts after one,
  // so the fall that ends a start condition never counts as a bit.
  reg        rise_seen;

  // Incoming bit joined to the seven already shifted in.
  wire [7:0] rx_byte = {shreg[6:0], sda};

  // ------------------------------------------------------------------
  // Receive and answer
  // ------------------------------------------------------------------

  // Address match combining type and select checks.
  function addr_match;
    input [7:0] b;
    input [2:0] sel;
    begin
      addr_match = (b[7:4] == `EEP_DEV_TYPE) && (b[3:1] == sel);
    end
  endfunction

  // Bit sampling on rising clock, line driving on falling clock.
  // Line changes wait for a clock fall, so the data line never moves with the clock high.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state     <= ST_IDLE;
      ret_state <= ST_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 3'h0;
      addr      <= 15'h0000;
      page_base <= 15'h0000;
      have_data <= 1'b0;
      ack_drive <= 1'b0;
      ack_phase <= 1'b0;
      tx_ack_ok <= 1'b0;
      rise_seen <= 1'b0;
      addr_hi   <= 8'h00;
      page_vld  <= {`EEP_PAGE_BYTES{1'b0}};
      sda_o     <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else if (start_ev) begin
      // RQ22 start abandons transfer
      state     <= ST_DEV;
      bitcnt    <= 3'h0;
      rise_seen <= 1'b0;
      sda_oe_o  <= 1'b0;
      ack_phase <= 1'b0;
    end else if (stop_ev) begin
      // RQ22 stop releases line
      state     <= ST_IDLE;
      sda_oe_o  <= 1'b0;
      ack_phase <= 1'b0;
      have_data <= 1'b0;
      page_vld  <= have_data ? page_vld : {`EEP_PAGE_BYTES{1'b0}};
    end else if (state != ST_IDLE) begin
      if (scl_rise) begin
        rise_seen <= 1'b1;
        if (ack_phase) begin
          // RQ7 sample master acknowledge
          tx_ack_ok <= ~sda;
        end else if (state != ST_RDAT) begin
          // While sending, the byte stays put so that it can be indexed.
          shreg <= rx_byte;
        end
      end
      if (scl_fall && rise_seen) begin
        rise_seen <= 1'b0;
        if (ack_phase) begin
          // Ninth clock finished: release the line, or drive the first bit of the next byte when a read goes on, and move on.
          ack_phase <= 1'b0;
          sda_oe_o  <= 1'b0;
          bitcnt    <= 3'h0;
          // RQ14 read goes on only while acknowledged
          if ((state == ST_RDAT) ? tx_ack_ok : ack_drive) begin
            state <= ret_state;
            if (ret_state == ST_RDAT) begin
              sda_oe_o <= ~mem[addr][`EEP_BIT_LAST];
              shreg    <= mem[addr];
            end
          end else begin
            state <= ST_IDLE;
          end
        end else if (state == ST_RDAT) begin
          if (bitcnt == `EEP_BIT_LAST) begin
            // RQ7 release for master acknowledge
            sda_oe_o  <= 1'b0;
            ack_phase <= 1'b1;
            ack_drive <= 1'b0;
            addr      <= addr + 15'h0001;
            ret_state <= ST_RDAT;
          end else begin
            bitcnt   <= bitcnt + 3'h1;
            sda_oe_o <= ~shreg[6 - bitcnt];
          end
        end else if (bitcnt == `EEP_BIT_LAST) begin
          ack_phase <= 1'b1;
          ack_drive <= 1'b1;
          case (state)
            ST_DEV: begin
              // RQ2 RQ3 RQ4 RQ20 address check
              if (!addr_match(shreg, sel_s2) || programming) begin
                ack_drive <= 1'b0;
              end
              // RQ5 direction select
              ret_state <= (shreg[0] == `EEP_RD_BIT) ? ST_RDAT : ST_AHI;
            end
            ST_AHI: begin
              // RQ9 RQ18 high byte, top bit dropped
              addr_hi   <= shreg & `EEP_HI_MASK;
              ret_state <= ST_ALO;
            end
            ST_ALO: begin
              // RQ8 second address byte
              addr      <= {addr_hi[6:0], shreg};
              page_base <= {addr_hi[6:0], shreg} & ~`EEP_PAGE_MASK;
              ret_state <= ST_WDAT;
              // A new write starts with an empty page, so bytes left from
              // an earlier page can never be committed into this one.
              page_vld  <= {`EEP_PAGE_BYTES{1'b0}};
              have_data <= 1'b0;
            end
            ST_WDAT: begin
              if (wp) begin
                // RQ10 RQ11 protected data refused
                ack_drive <= 1'b0;
              end else begin
                // RQ16 RQ19 buffer and wrap in page
                page[addr[5:0]]     <= shreg;
                page_vld[addr[5:0]] <= 1'b1;
                have_data           <= 1'b1;
                addr <= page_base | ((addr + 15'h0001) & `EEP_PAGE_MASK);
              end
              ret_state <= ST_WDAT;
            end
            default: ack_drive <= 1'b0;
          endcase
          // RQ6 RQ17 pull low only
          sda_o    <= 1'b0;
          sda_oe_o <= (state == ST_DEV) ? (addr_match(shreg, sel_s2) && !programming)
                                        : !(state == ST_WDAT && wp);
        end else begin
          bitcnt <= bitcnt + 3'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Self-timed program cycle
  // ------------------------------------------------------------------
  // RQ1 program at stop
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      programming <= 1'b0;
      twr_cnt     <= 24'h000000;
      prog_idx    <= 7'h00;
      busy_o      <= 1'b0;
    end else begin
      // The output lags the internal flag by one clock to come from a flop.
      busy_o <= programming;
      if (!programming) begin
        if (stop_ev && have_data && state == ST_WDAT) begin
          programming <= 1'b1;
          twr_cnt     <= 24'h000000;
          prog_idx    <= 7'h00;
        end
      end else begin
        // The buffer is read while new frames may start; the address is
        // refused while busy, so the buffer cannot change under the commit.
        // Commit the buffered page one byte per clock, then hold busy.
        if (prog_idx < `EEP_PAGE_BYTES) begin
          if (page_vld[prog_idx[5:0]]) begin
            mem[page_base | {9'h000, prog_idx[5:0]}] <= page[prog_idx[5:0]];
          end
          prog_idx <= prog_idx + 7'h01;
        end
        // The count ends exactly at the programmed time, never above it.
        twr_cnt <= twr_cnt + 24'h000001;
        if (twr_cnt == TWR_CYCLES - 1) begin
          programming <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: dv/eep_slave_checker.sv */
`timescale 1ns/1ns
// Watches the slave pins; assertions only.
module eep_slave_checker #(
  parameter TWR_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_protect_i,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Counts busy cycles, since a repetition cannot reach the program time.
  int bcnt;
  always @(posedge clk_i) begin
    if (sys_rst_i || !busy_o) bcnt <= 0;
    else bcnt <= bcnt + 1;
  end
  a_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_wire_low: assert property (sda_oe_o |-> !sda_i)
    else $error("wire not low while driven");
  a_busy_idle: assert property ($rose(busy_o) |-> scl_i && sda_i)
    else $error("program cycle without stop");
  a_busy_wp: assert property ($rose(busy_o) |-> !write_protect_i)
    else $error("program cycle while protected");
  a_busy_hold: assert property ($rose(busy_o) |=> busy_o[*8])
    else $error("program cycle too short");
  a_busy_len: assert property ($fell(busy_o) |-> bcnt >= TWR_CYCLES - 4)
    else $error("program cycle ended early");
  a_busy_bound: assert property (bcnt <= TWR_CYCLES + 4)
    else $error("program cycle overran");
  a_no_ack_busy: assert property (busy_o && $past(busy_o) |-> !sda_oe_o)
    else $error("answer while programming");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed with clock high");
  a_ack_width: assert property ($rose(sda_oe_o) |=> sda_oe_o[*5])
    else $error("low pulse too short");
endmodule
bind eep_slave eep_slave_checker #(.TWR_CYCLES(TWR_CYCLES)) i_eep_slave_checker (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i), .busy_o(busy_o));

/* File: dv/eep_i2c_master.sv */
`timescale 1ns/1ns
// Bus master model; its clock stands high outside frames.
module eep_i2c_master (
  output logic      scl_o,
  output logic      sda_rel_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  task start;
    #200 sda_rel_o = 1'b1;
    #50 scl_o = 1'b1;
    #100 sda_rel_o = 1'b0;
    #50 scl_o = 1'b0;
  endtask
  task stop;
    #200 sda_rel_o = 1'b0;
    #50 scl_o = 1'b1;
    #100 sda_rel_o = 1'b1;
    #50;
  endtask
  // data moves late in the low phase, 200 ns after the fall, so a slow release never looks like a stop.
  task bits9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #200 sda_rel_o = tx[i];
      #50 scl_o = 1'b1;
      #100 rx[i] = sda_i;
      #50 scl_o = 1'b0;
    end
  endtask
endmodule

/* File: dv/eep_slave_tb.sv */
`timescale 1ns/1ns
`include "eep_regs.vh"
module eep_slave_tb;
  logic             clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [2:0]       pins = 3'h0;
  logic             wp = 1'b0;
  logic             scl, rel, sda_o, sda_oe_o, busy_o;
  wire              sda = rel & ~sda_oe_o;
  logic [8:0]       rx;
  logic [7:0]       hi, lo, d;
  logic [7:0]       mem [0:`EEP_MEM_WORDS-1];
  logic [31:0]      seed = 32'h0000AAD1;
  int               n_errors = 0, cmp_count = 0, cyc = 0, a, n;
  initial forever #25 clk_i = ~clk_i;
  eep_slave #(.TWR_CYCLES(200)) i_eep_slave (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .device_select_pin_0_i(pins[0]), .device_select_pin_1_i(pins[1]),
    .device_select_pin_2_i(pins[2]), .write_protect_i(wp), .busy_o(busy_o));
  eep_i2c_master i_m (.scl_o(scl), .sda_rel_o(rel), .sda_i(sda));
  function logic [7:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [7:0] sa(input logic [2:0] s, input logic rd);
    return {`EEP_DEV_TYPE, s, rd};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task wb(input logic [7:0] b, input logic ack);
    i_m.bits9({b, 1'b1}, rx);
    chk(32'(rx[0]), 32'(!ack));
  endtask
  // Sets the address by a write header, then reads one whole page back.
  task rd_page(input logic [7:0] h, input logic [7:0] l);
    i_m.start();
    wb(sa(pins, 1'b0), 1'b1);
    wb(h, 1'b1);
    wb(l, 1'b1);
    i_m.start();
    wb(sa(pins, 1'b1), 1'b1);
    for (int i = 0; i < 64; i++) begin
      i_m.bits9({8'hFF, i == 63}, rx);
      chk(32'(rx[8:1]), 32'(mem[{h[6:0], l} + i]));
    end
    i_m.stop();
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A hang counts as a mismatch and still ends in the verdict.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(32'({sda_oe_o, busy_o}), 32'h0);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_i) pins = 3'(rnd());
      i_m.start();
      wb({`EEP_DEV_TYPE ^ 4'h3, pins, 1'b0}, 1'b0);
      i_m.start();
      wb(sa(pins ^ 3'(k % 7 + 1), 1'b0), 1'b0);
      i_m.start();
      wb(sa(pins, 1'b0), 1'b1);
      i_m.stop();
    end
    $display("decode test done");
    hi = rnd() | 8'h80;
    lo = rnd() | 8'h3C;
    a = {hi[6:0], lo};
    i_m.start();
    wb(sa(pins, 1'b0), 1'b1);
    wb(hi, 1'b1);
    wb(lo, 1'b1);
    for (int i = 0; i < 66; i++) begin
      d = rnd();
      mem[(a & 32'h00007FC0) | ((a + i) & 32'h0000003F)] = d;
      wb(d, 1'b1);
    end
    i_m.stop();
    repeat (4) @(negedge clk_i);
    chk(32'(busy_o), 32'h1);
    i_m.start();
    wb(sa(pins, 1'b0), 1'b0);
    i_m.stop();
    n = 0;
    do begin
      i_m.start();
      i_m.bits9({sa(pins, 1'b0), 1'b1}, rx);
      i_m.stop();
      n++;
    end while (rx[0] !== 1'b0 && n < 20);
    chk(32'(rx[0]), 32'h0);
    rd_page(hi, lo & 8'hC0);
    $display("page test done");
    @(negedge clk_i) wp = 1'b1;
    i_m.start();
    wb(sa(pins, 1'b0), 1'b1);
    wb(hi, 1'b1);
    wb(lo, 1'b1);
    wb(rnd(), 1'b0);
    i_m.stop();
    repeat (10) @(negedge clk_i);
    chk(32'(busy_o), 32'h0);
    rd_page(hi, lo & 8'hC0);
    @(negedge clk_i) wp = 1'b0;
    $display("protect test done");
    give_verdict();
  end
endmodule
